// ### cdbr_alu_model.sv
// Purpose: behavioural alu standing in for the core's arithmetic unit
// Assumes: operand a is the visible accumulator, operand b the bus byte
// Notes:   combinational, covers the operation classes the bench issues except adjust, which passes the bus byte through
`timescale 1ns/1ns
module cdbr_alu_model
(
  input  wire cdbr_pkg::cdbr_op_t opCode,
  input  wire logic [7:0]         accIn,
  input  wire logic [7:0]         busIn,
  output logic [7:0]              aluResult,
  output logic                    aluCarry,
  output logic                    aluHalf,
  output logic                    aluOvf
);
  import cdbr_pkg::*;
  logic [8:0] sum;
  ////////////////////////////////////////////////////////////////////
  // result, nibble carry and signed overflow per class
  always_comb
  begin
    sum = 9'h000;
    aluHalf = 1'b0;
    aluOvf = 1'b0;
    case (opCode)
      OP_ADD:
      begin
        sum = {1'b0, accIn} + {1'b0, busIn};
        aluHalf = ({1'b0, accIn[3:0]} + {1'b0, busIn[3:0]}) > 5'h0f;
        aluOvf = (accIn[7] == busIn[7]) && (sum[7] != accIn[7]);
      end
      OP_SUB:
      begin
        sum = {1'b0, accIn} - {1'b0, busIn};  // top bit is the borrow
        aluHalf = accIn[3:0] < busIn[3:0];
        aluOvf = (accIn[7] != busIn[7]) && (sum[7] != accIn[7]);
      end
      OP_AND:
      begin
        sum = {1'b0, accIn & busIn};
        aluHalf = 1'b1;
      end
      OP_OR: sum = {1'b0, accIn | busIn};
      // increment works on the bus byte, the register being bumped
      OP_INC:
      begin
        sum = {1'b0, busIn} + 9'h001;
        aluHalf = (busIn[3:0] == 4'hf);
        aluOvf = (busIn == 8'h7f);
      end
      OP_NEG:
      begin
        sum = 9'h000 - {1'b0, accIn};  // top bit is the borrow
        aluHalf = (accIn[3:0] != 4'h0);
        aluOvf = (accIn == 8'h80);
      end
      OP_CPL: sum = {1'b0, ~accIn};
      OP_ROT_ACC: sum = {accIn[7], accIn[6:0], accIn[7]};  // left circular
      default: sum = {1'b0, busIn};
    endcase
  end
  assign aluResult = sum[7:0];
  assign aluCarry  = sum[8];
endmodule // cdbr_alu_model

// ### cdbr_flag_unit.sv
// Purpose: next value of the flag byte for one operation class
// Assumes: alu supplies result, carry, half carry and overflow
// Notes:   purely combinational, unused flag bits forced low
`timescale 1ns/1ns
module cdbr_flag_unit
(
  input  wire cdbr_pkg::cdbr_op_t op,
  input  wire logic [7:0]         oldFlags,
  input  wire logic [7:0]         result,
  input  wire logic               aluCarry,
  input  wire logic               aluHalf,
  input  wire logic               aluOvf,
  output logic [7:0]              newFlags
);
  import cdbr_pkg::*;

  logic par;
  logic zer;
  assign par = cdbr_even(result);
  assign zer = (result == RST_BYTE);

  ////////////////////////////////////////////////////////////////////
  // per-class flag update
  always_comb
  begin
    newFlags = oldFlags;
    case (op)
      // RULE9 carry and borrow
      OP_ADD, OP_SUB:
      begin
        newFlags[FB_S] = result[7];
        newFlags[FB_Z] = zer;
        newFlags[FB_H] = aluHalf;
        newFlags[FB_PV] = aluOvf;
        newFlags[FB_N] = (op == OP_SUB);
        newFlags[FB_C] = aluCarry;
      end
      OP_INC, OP_DEC:
      begin
        newFlags[FB_S] = result[7];
        newFlags[FB_Z] = zer;
        newFlags[FB_H] = aluHalf;
        newFlags[FB_PV] = aluOvf;
        newFlags[FB_N] = (op == OP_DEC);
      end
      // RULE16 parity for logic
      OP_AND, OP_OR, OP_ROT_SHIFT, OP_IN_IND:
      begin
        newFlags[FB_S] = result[7];
        newFlags[FB_Z] = zer;
        newFlags[FB_H] = (op == OP_AND);
        newFlags[FB_PV] = par;
        newFlags[FB_N] = 1'b0;
        if (op == OP_ROT_SHIFT)
          newFlags[FB_C] = aluCarry;
        // RULE11 logic clears carry
        else if (op != OP_IN_IND)
          newFlags[FB_C] = 1'b0;
      end
      // RULE6 accumulator rotate class
      OP_ROT_ACC:
      begin
        newFlags[FB_H] = 1'b0;
        newFlags[FB_N] = 1'b0;
        newFlags[FB_C] = aluCarry;
      end
      // RULE12 keeps n for adjust
      OP_DAA:
      begin
        newFlags[FB_S] = result[7];
        newFlags[FB_Z] = zer;
        newFlags[FB_H] = aluHalf;
        newFlags[FB_PV] = par;
        newFlags[FB_C] = aluCarry;
      end
      OP_NEG:
      begin
        newFlags[FB_S] = result[7];
        newFlags[FB_Z] = zer;
        newFlags[FB_H] = aluHalf;
        newFlags[FB_PV] = aluOvf;
        newFlags[FB_N] = 1'b1;
        newFlags[FB_C] = aluCarry;
      end
      // RULE13 complement sets n
      OP_CPL:
      begin
        newFlags[FB_H] = 1'b1;
        newFlags[FB_N] = 1'b1;
      end
      // RULE10 set and flip carry
      OP_SCF:
      begin
        newFlags[FB_H] = 1'b0;
        newFlags[FB_N] = 1'b0;
        newFlags[FB_C] = 1'b1;
      end
      OP_CCF:
      begin
        newFlags[FB_N] = 1'b0;
        newFlags[FB_C] = ~oldFlags[FB_C];
      end
      // RULE14 clears n
      OP_BLK_XFER, OP_LD_IR, OP_BIT:
      begin
        newFlags[FB_N] = 1'b0;
        newFlags[FB_PV] = aluOvf;
        newFlags[FB_H] = (op == OP_BIT);
        if (op != OP_BLK_XFER)
          newFlags[FB_Z] = zer;
        if (op == OP_LD_IR)
          newFlags[FB_S] = result[7];
      end
      OP_BLK_IO, OP_BLK_SRCH:
      begin
        newFlags[FB_Z] = zer;
        newFlags[FB_N] = 1'b1;
        if (op == OP_BLK_SRCH)
        begin
          newFlags[FB_S] = result[7];
          newFlags[FB_PV] = aluOvf;
        end
      end
      default:
        newFlags = oldFlags;
    endcase
    newFlags = newFlags & FLAG_USED;
  end
endmodule // cdbr_flag_unit

// ### cdbr_pkg.sv
// Purpose: shared constants and types for the dual-bank register file
// Assumes: one core clock, 8-bit internal data bus
// Notes:   flag positions and bus offsets are fixed here only
package cdbr_pkg;
  localparam int DW = 8;
  // register index inside a bank
  localparam logic [2:0] IDX_ACC = 3'h0;
  localparam logic [2:0] IDX_FLG = 3'h1;
  localparam logic [2:0] IDX_GEN0 = 3'h2;
  localparam logic [2:0] IDX_GENL = 3'h7;
  // flag bit positions
  localparam int FB_C = 0;
  localparam int FB_N = 1;
  localparam int FB_PV = 2;
  localparam int FB_H = 4;
  localparam int FB_Z = 6;
  localparam int FB_S = 7;
  localparam logic [7:0] FLAG_USED = 8'hd7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // avalon register map, byte addresses
  localparam int AW = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam int CB_FREEZE = 0;
  localparam int SB_ACCBANK = 0;
  localparam int SB_GENBANK = 1;
  localparam int SB_FREEZE = 2;
  // operation classes issued by the decoder
  typedef enum logic [4:0] {
    OP_NONE, OP_LOAD, OP_ADD, OP_SUB, OP_INC, OP_DEC, OP_AND, OP_OR,
    OP_ROT_ACC, OP_ROT_SHIFT, OP_DAA, OP_NEG, OP_CPL, OP_SCF, OP_CCF,
    OP_IN_IND, OP_BLK_IO, OP_BLK_SRCH, OP_BLK_XFER, OP_LD_IR, OP_BIT,
    OP_SWAP_ACC, OP_SWAP_GEN, OP_PUSH_F, OP_POP_F
  } cdbr_op_t;
  // branch condition codes
  typedef enum logic [2:0] {
    CC_NZ, CC_Z, CC_NC, CC_C, CC_PO, CC_PE, CC_P, CC_M
  } cdbr_cond_t;
  // even parity of a byte gives one
  function automatic logic cdbr_even(input logic [7:0] b);
    return ~^b;
  endfunction
  // ops whose result lands in the accumulator
  function automatic logic cdbr_to_acc(input cdbr_op_t op);
    return op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_ROT_ACC, OP_DAA,
                      OP_NEG, OP_CPL};
  endfunction
endpackage

// ### cdbr_regs.sv
// Purpose: main and alternate working register banks with flag logic
// Assumes: decoder issues one operation per cycle, alu is combinational
// Notes:   avalon slave gives a freeze control and bank status
// Operation
// RULE1: two eight-byte banks, one visible
// RULE2: accumulator swap exchanges A and flags
// RULE3: general swap exchanges six byte registers
// RULE4: accumulator takes arithmetic and logic results
// RULE5: accumulator has extra load forms
// RULE6: accumulator rotate is a short instruction
// RULE7: flags readable only by push
// RULE8: branches test S, Z, PV, C only
// RULE9: carry from add, borrow from subtract
// RULE10: set carry and complement carry
// RULE11: carry updates, logic clears, others keep
// RULE12: n with h steers decimal adjust (the alu takes no flag inputs and passes the bus byte through for adjust)
// RULE13: n set by subtract class operations
// RULE14: n cleared by add class operations
// RULE15: one shared internal byte bus
// RULE16: pv is parity or signed overflow
// RULE17: sign copies result bit seven
// RULE18: swap toggles bank, twice restores
`timescale 1ns/1ns
module cdbr_regs
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 opValid,
  input  wire cdbr_pkg::cdbr_op_t   opCode,
  input  wire logic [2:0]           dstSel,
  input  wire logic [2:0]           srcSel,
  input  wire cdbr_pkg::cdbr_cond_t condSel,
  input  wire logic [7:0]           busIn,
  input  wire logic [7:0]           aluResult,
  input  wire logic                 aluCarry,
  input  wire logic                 aluHalf,
  input  wire logic                 aluOvf,
  output logic [7:0]                busOut,
  output logic [7:0]                accOut,
  output logic [7:0]                aluFlags,
  output logic                      condMet,
  input  wire logic [3:0]           avsAddress,
  input  wire logic                 avsRead,
  input  wire logic                 avsWrite,
  input  wire logic [31:0]          avsWriteData,
  input  wire logic [3:0]           avsByteEnable,
  output logic [31:0]               avsReadData,
  output logic                      avsWaitRequest
);
  import cdbr_pkg::*;

  // RULE1 visible and alternate banks
  logic [7:0] visQ [0:7];
  logic [7:0] altQ [0:7];
  logic       accBank_q;
  logic       genBank_q;
  logic       freeze_q;
  logic [7:0] busOut_q;
  logic       condMet_q;
  logic [31:0] rdData_q;
  logic       waitReq_q;
  logic [7:0] flagsD;
  logic       opGo;
  logic       busReq;

  assign opGo = opValid && !freeze_q;
  assign busReq = avsRead || avsWrite;

  ////////////////////////////////////////////////////////////////////
  // flag computation
  cdbr_flag_unit uFlags
  (
    .op       (opCode),
    .oldFlags (visQ[IDX_FLG]),
    .result   (aluResult),
    .aluCarry (aluCarry),
    .aluHalf  (aluHalf),
    .aluOvf   (aluOvf),
    .newFlags (flagsD)
  );

  ////////////////////////////////////////////////////////////////////
  // visible bank writes and exchanges
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        visQ[i] <= RST_BYTE;
        altQ[i] <= RST_BYTE;
      end
    end
    else if (opGo)
    begin
      case (opCode)
        // RULE2 exchange accumulator and flags
        OP_SWAP_ACC:
        begin
          for (int i = 0; i < 2; i++)
          begin
            visQ[i] <= altQ[i];
            altQ[i] <= visQ[i];
          end
        end
        // RULE3 exchange the six general bytes
        OP_SWAP_GEN:
        begin
          for (int i = 2; i < 8; i++)
          begin
            visQ[i] <= altQ[i];
            altQ[i] <= visQ[i];
          end
        end
        // RULE5 any load form lands here
        OP_LOAD, OP_IN_IND:
        begin
          if (dstSel != IDX_FLG)
            visQ[dstSel] <= busIn;
          if (opCode == OP_IN_IND)
            visQ[IDX_FLG] <= flagsD;
        end
        // RULE7 flags enter only from the stack
        OP_POP_F:
          visQ[IDX_FLG] <= busIn & FLAG_USED;
        OP_INC, OP_DEC, OP_ROT_SHIFT:
        begin
          if (dstSel != IDX_FLG)
            visQ[dstSel] <= aluResult;
          visQ[IDX_FLG] <= flagsD;
        end
        default:
        begin
          // RULE4 results into accumulator
          if (cdbr_to_acc(opCode))
            visQ[IDX_ACC] <= aluResult;
          visQ[IDX_FLG] <= flagsD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // RULE18 bank select toggles per exchange
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      accBank_q <= 1'b0;
      genBank_q <= 1'b0;
    end
    else if (opGo)
    begin
      if (opCode == OP_SWAP_ACC)
        accBank_q <= ~accBank_q;
      if (opCode == OP_SWAP_GEN)
        genBank_q <= ~genBank_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // RULE15 shared bus drive, flags only on push
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      busOut_q <= RST_BYTE;
    else if (srcSel == IDX_FLG)
      busOut_q <= (opValid && opCode == OP_PUSH_F) ? visQ[IDX_FLG] : RST_BYTE;
    else
      busOut_q <= visQ[srcSel];
  end

  ////////////////////////////////////////////////////////////////////
  // RULE8 condition test on four flags
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      condMet_q <= 1'b0;
    else
    begin
      case (condSel)
        CC_NZ:   condMet_q <= ~visQ[IDX_FLG][FB_Z];
        CC_Z:    condMet_q <= visQ[IDX_FLG][FB_Z];
        CC_NC:   condMet_q <= ~visQ[IDX_FLG][FB_C];
        CC_C:    condMet_q <= visQ[IDX_FLG][FB_C];
        CC_PO:   condMet_q <= ~visQ[IDX_FLG][FB_PV];
        CC_PE:   condMet_q <= visQ[IDX_FLG][FB_PV];
        CC_P:    condMet_q <= ~visQ[IDX_FLG][FB_S];
        CC_M:    condMet_q <= visQ[IDX_FLG][FB_S];
        default: condMet_q <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // avalon handshake: one wait cycle, then answer
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      waitReq_q <= 1'b1;
    else if (busReq && waitReq_q)
      waitReq_q <= 1'b0;
    else
      waitReq_q <= 1'b1;
  end

  // control register write, lands at the edge that ends the answer cycle, with waitrequest low
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      freeze_q <= 1'b0;
    else if (avsWrite && !waitReq_q && avsAddress == OFS_CTRL && avsByteEnable[0])
      freeze_q <= avsWriteData[CB_FREEZE];
  end

  // read data, unmapped reads give zero
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdData_q <= '0;
    else if (avsRead && waitReq_q)
    begin
      rdData_q <= '0;
      if (avsAddress == OFS_CTRL)
        rdData_q[CB_FREEZE] <= freeze_q;
      else if (avsAddress == OFS_STAT)
      begin
        rdData_q[SB_ACCBANK] <= accBank_q;
        rdData_q[SB_GENBANK] <= genBank_q;
        rdData_q[SB_FREEZE] <= freeze_q;
      end
    end
  end

  assign busOut = busOut_q;
  assign accOut = visQ[IDX_ACC];
  assign aluFlags = visQ[IDX_FLG];
  assign condMet = condMet_q;
  assign avsReadData = rdData_q;
  assign avsWaitRequest = waitReq_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence accSwapOnce;
    opGo && opCode == OP_SWAP_ACC;
  endsequence

  sequence accSwapTwice;
    accSwapOnce ##1 (!opGo) ##1 accSwapOnce;
  endsequence

  accSwap_a: assert property (accSwapOnce |=> // RULE2
    visQ[IDX_ACC] == $past(altQ[IDX_ACC]) && $stable(visQ[IDX_GEN0]))
    else $error("acc swap wrong");
  genSwap_a: assert property (opGo && opCode == OP_SWAP_GEN |=> // RULE3
    visQ[IDX_GENL] == $past(altQ[IDX_GENL]) && $stable(visQ[IDX_ACC]))
    else $error("general swap wrong");
  swapRestore_a: assert property (accSwapTwice |=> // RULE18
    accBank_q == $past(accBank_q, 3))
    else $error("double swap not restored");
  addCarry_a: assert property (opGo && opCode == OP_ADD |=> // RULE9
    visQ[IDX_FLG][FB_C] == $past(aluCarry) && !visQ[IDX_FLG][FB_N])
    else $error("add carry or n wrong");
  logicCarry_a: assert property (opGo && opCode inside {OP_AND, OP_OR} |=> // RULE11
    !visQ[IDX_FLG][FB_C] && visQ[IDX_ACC] == $past(aluResult))
    else $error("logic op carry not cleared");
  carryCmd_a: assert property (opGo && opCode == OP_CCF |=> // RULE10
    visQ[IDX_FLG][FB_C] != $past(visQ[IDX_FLG][FB_C]))
    else $error("carry complement wrong");
  subN_a: assert property (opGo && opCode inside {OP_SUB, OP_DEC, OP_NEG} |=> // RULE13
    visQ[IDX_FLG][FB_N])
    else $error("n not set");
  parityPv_a: assert property (opGo && opCode == OP_OR |=> // RULE16
    visQ[IDX_FLG][FB_PV] == cdbr_even($past(aluResult)))
    else $error("parity flag wrong");
  signCopy_a: assert property (opGo && opCode == OP_SUB |=> // RULE17
    visQ[IDX_FLG][FB_S] == $past(aluResult[7]))
    else $error("sign flag wrong");
  flagHide_a: assert property (srcSel == IDX_FLG && !(opValid && opCode == OP_PUSH_F) |=> // RULE7
    busOut == RST_BYTE)
    else $error("flags leaked on bus");
  condZ_a: assert property (condSel == CC_Z ##1 1'b1 |-> // RULE8
    condMet == $past(visQ[IDX_FLG][FB_Z]))
    else $error("zero test wrong");
  busAnswer_a: assert property (busReq && avsWaitRequest |=>
    !avsWaitRequest ##1 avsWaitRequest)
    else $error("bus answer timing wrong");
endmodule // cdbr_regs

// ### cdbr_regs_bench.sv
// Purpose: self-checking bench for the dual-bank register file
// Assumes: alu model on the far side, avalon master tasks
// Notes:   expected flag bytes are worked out by hand per operation
`timescale 1ns/1ns
module cdbr_regs_bench;
  import cdbr_pkg::*;
  logic        mclk, resetn, opValid, aluCarry, aluHalf, aluOvf, condMet;
  cdbr_op_t    opCode;
  cdbr_cond_t  condSel;
  logic [2:0]  dstSel, srcSel;
  logic [7:0]  busIn, aluResult, busOut, accOut, aluFlags;
  logic [3:0]  avsAddress, avsByteEnable;
  logic        avsRead, avsWrite, avsWaitRequest;
  logic [31:0] avsWriteData, avsReadData, rd;
  int          miscompares, cmpCount;
  ////////////////////////////////////////////////////////////////////
  cdbr_regs cdbr_regs_inst (.mclk(mclk), .resetn(resetn), .opValid(opValid),
    .opCode(opCode), .dstSel(dstSel), .srcSel(srcSel), .condSel(condSel),
    .busIn(busIn), .aluResult(aluResult), .aluCarry(aluCarry), .aluHalf(aluHalf),
    .aluOvf(aluOvf), .busOut(busOut), .accOut(accOut), .aluFlags(aluFlags),
    .condMet(condMet), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));
  cdbr_alu_model cdbr_alu_model_inst (.opCode(opCode), .accIn(accOut), .busIn(busIn),
    .aluResult(aluResult), .aluCarry(aluCarry), .aluHalf(aluHalf), .aluOvf(aluOvf));
  ////////////////////////////////////////////////////////////////////
  // free running core clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmpCount++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    avsRead <= ~wr;
    avsWrite <= wr;
    avsAddress <= adr;
    avsWriteData <= wd;
    for (n = 0; n < 16; n++)
    begin
      @(posedge mclk);
      if (avsWaitRequest === 1'b0)
        break;
    end
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n == 16)
    begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic avsRd(input logic [3:0] adr, input logic [31:0] exp);
    avs(1'b0, adr, 32'h0);
    chk("readdata", exp, rd);
  endtask
  // one operation strobe, ends on the following falling edge
  task automatic doOp(input cdbr_op_t op, input logic [2:0] dst, input logic [7:0] d);
    @(posedge mclk);
    opValid <= 1'b1;
    opCode <= op;
    dstSel <= dst;
    busIn <= d;
    @(posedge mclk);
    opValid <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] f);
    chk("accOut", {24'h0, a}, {24'h0, accOut});
    chk("aluFlags", {24'h0, f}, {24'h0, aluFlags});
  endtask
  task automatic peek(input logic [2:0] sel, input logic [7:0] exp);
    @(posedge mclk);
    srcSel <= sel;
    @(posedge mclk);
    @(negedge mclk);
    chk("busOut", {24'h0, exp}, {24'h0, busOut});
  endtask
  // walks all eight branch conditions against the present flags
  task automatic conds(input logic [7:0] expv);
    for (int c = 0; c < 8; c++)
    begin
      @(posedge mclk);
      condSel <= cdbr_cond_t'(c);
      @(posedge mclk);
      @(negedge mclk);
      chk("condMet", {31'h0, expv[c]}, {31'h0, condMet});
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {resetn, opValid, avsRead, avsWrite, dstSel, srcSel, busIn} = '0;
    {avsAddress, avsWriteData, miscompares, cmpCount} = '0;
    opCode = OP_NONE;
    condSel = CC_NZ;
    avsByteEnable = 4'hf;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    acc(8'h00, 8'h00);
    avsRd(OFS_STAT, 32'h0);
    doOp(OP_LOAD, IDX_ACC, 8'h7f);
    doOp(OP_ADD, IDX_ACC, 8'h01);
    acc(8'h80, 8'h94);
    doOp(OP_SUB, IDX_ACC, 8'h01);
    acc(8'h7f, 8'h16);
    doOp(OP_ADD, IDX_ACC, 8'h81);
    acc(8'h00, 8'h51);
    conds(8'h5a);
    doOp(OP_SUB, IDX_ACC, 8'h01);
    acc(8'hff, 8'h93);
    doOp(OP_AND, IDX_ACC, 8'h0f);
    acc(8'h0f, 8'h14);
    doOp(OP_OR, IDX_ACC, 8'h80);
    acc(8'h8f, 8'h80);
    conds(8'h95);
    doOp(OP_SCF, IDX_ACC, 8'h00);
    acc(8'h8f, 8'h81);
    doOp(OP_CCF, IDX_ACC, 8'h00);
    acc(8'h8f, 8'h80);
    peek(IDX_FLG, 8'h00);
    doOp(OP_PUSH_F, IDX_ACC, 8'h00);
    chk("pushed", 32'h80, {24'h0, busOut});
    doOp(OP_POP_F, IDX_ACC, 8'hff);
    acc(8'h8f, FLAG_USED);
    doOp(OP_SWAP_ACC, IDX_ACC, 8'h00);
    acc(8'h00, 8'h00);
    avsRd(OFS_STAT, 32'h1);
    doOp(OP_LOAD, IDX_ACC, 8'h3c);
    doOp(OP_SWAP_ACC, IDX_ACC, 8'h00);
    acc(8'h8f, FLAG_USED);
    doOp(OP_LOAD, IDX_GEN0, 8'h11);
    doOp(OP_LOAD, IDX_GENL, 8'h77);
    peek(IDX_GEN0, 8'h11);
    doOp(OP_SWAP_GEN, IDX_ACC, 8'h00);
    peek(IDX_GEN0, 8'h00);
    acc(8'h8f, FLAG_USED);
    avsRd(OFS_STAT, 32'h2);
    doOp(OP_SWAP_GEN, IDX_ACC, 8'h00);
    peek(IDX_GENL, 8'h77);
    avs(1'b1, OFS_CTRL, 32'h1);
    avsRd(OFS_STAT, 32'h4);
    doOp(OP_LOAD, IDX_ACC, 8'h99);
    acc(8'h8f, FLAG_USED);
    avs(1'b1, OFS_STAT, 32'hff);
    avsRd(4'h8, 32'h0);
    avs(1'b1, OFS_CTRL, 32'h0);
    avsByteEnable <= 4'he;
    avs(1'b1, OFS_CTRL, 32'h1);
    avsByteEnable <= 4'hf;
    avsRd(OFS_STAT, 32'h0);
    doOp(OP_LOAD, IDX_ACC, 8'h99);
    acc(8'h99, FLAG_USED);
    // negate, adjust, increment, complement and rotate classes
    doOp(OP_NEG, IDX_ACC, 8'h00);
    acc(8'h67, 8'h13);
    doOp(OP_DAA, IDX_ACC, 8'h00);
    acc(8'h00, 8'h46);
    doOp(OP_INC, IDX_GEN0, 8'h7f);
    acc(8'h00, 8'h94);
    peek(IDX_GEN0, 8'h80);
    doOp(OP_CPL, IDX_ACC, 8'h00);
    acc(8'hff, 8'h96);
    doOp(OP_ROT_ACC, IDX_ACC, 8'h00);
    acc(8'hff, 8'h85);
    // back to back exchanges restore, a third one leaves the bank flipped
    doOp(OP_SWAP_ACC, IDX_ACC, 8'h00);
    doOp(OP_SWAP_ACC, IDX_ACC, 8'h00);
    acc(8'hff, 8'h85);
    doOp(OP_SWAP_ACC, IDX_ACC, 8'h00);
    acc(8'h3c, 8'h00);
    avsRd(OFS_STAT, 32'h1);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    acc(8'h00, 8'h00);
    avsRd(OFS_STAT, 32'h0);
    conclude();
  end
endmodule // cdbr_regs_bench
